// [cam_cascade_arbiter.sv]
// Cascade arbitration for one of two paired search memory chips
`timescale 1ns/1ps
`default_nettype none
module cam_cascade_arbiter import cascade_pkg::*; #(
  parameter int DW = 33
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_cascade_role_select,
  input wire logic [1:0] i_cascade_status_in,
  input wire logic i_output_permit_in,
  // Request start from the bus front end
  input wire logic i_req_start,
  input wire logic [2:0] i_req_code,
  input wire logic [ID_W-1:0] i_local_connection_id,
  input wire logic [TEST_WORD_W-1:0] i_test_word,
  input wire logic i_parity_err,
  input wire logic i_cmd_err,
  // Local search result from the array
  input wire logic i_local_valid,
  input wire logic i_local_hit,
  input wire logic i_local_multi,
  // Request end and read data
  input wire logic i_req_end,
  input wire logic i_read_cycle,
  input wire logic [DW-1:0] i_read_data,
  output logic [1:0] o_cascade_status_out,
  output logic o_slave_output_permit,
  output logic o_req_ready,
  output logic o_selected,
  output logic o_respond,
  output logic [2:0] o_overall_status,
  output logic [DW-1:0] o_data_bus_lines_out,
  output logic o_data_bus_lines_oe
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [2:0] ci_lvl;
  logic role_lvl;
  logic [3:0] pin_lvl;

  pin_sync #(.W(4)) u_sync (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin({i_cascade_role_select, i_output_permit_in,
            i_cascade_status_in}),
    .o_level(pin_lvl)
  );
  assign ci_lvl = pin_lvl[2:0];
  assign role_lvl = pin_lvl[3];

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    phase_e phase;
    logic is_slave;
    logic searching;
    logic selected;
    logic faulted;
    logic local_known;
    logic local_hit;
    logic local_multi;
    logic [1:0] cs_out;
    logic permit;
    logic respond;
    logic [2:0] status;
    logic [DW-1:0] dout;
    logic oe;
  } arb_s;
  arb_s st_reg;
  arb_s st_next;

  logic is_search;
  logic id_slave;
  logic peer_miss;
  logic peer_hit;
  logic peer_idle;
  logic peer_direct;
  logic resp_now;
  logic [2:0] stat_now;

  assign is_search = (i_req_code >= REQ_SEARCH1) &&
                     (i_req_code <= REQ_SEARCH3);
  assign id_slave = (i_local_connection_id >= SLAVE_ID_BASE);
  assign peer_miss = (ci_lvl[1:0] == CS_MISS);
  assign peer_hit = (ci_lvl[1:0] == CS_HIT);
  assign peer_idle = (ci_lvl[1:0] == CS_IDLE);
  assign peer_direct = (ci_lvl[1:0] == CS_DIRECT);

  // ==========================================================
  // Responder decision and overall status at request end
  // ==========================================================
  always_comb begin
    resp_now = 1'b0;
    stat_now = ST_OK;
    if (!st_reg.is_slave) begin
      if (st_reg.faulted) begin
        // Errors only ever reported by the master
        resp_now = 1'b1;
        stat_now = i_parity_err ? ST_PAR_ERR : ST_CMD_ERR;
      end else if (st_reg.searching) begin
        if (peer_idle || peer_direct) begin
          resp_now = 1'b1;
          stat_now = ST_CASC_ERR;
        end else begin
          resp_now = st_reg.local_hit || !peer_hit;
          if (st_reg.local_hit && peer_hit) begin
            stat_now = ST_MULTI;
          end else if (st_reg.local_hit) begin
            stat_now = st_reg.local_multi ? ST_MULTI : ST_SINGLE;
          end else begin
            stat_now = ST_MISS;
          end
        end
      end else if (peer_idle) begin
        resp_now = 1'b1;
        stat_now = ST_CASC_ERR;
      end else begin
        // Any slave status but 10 (00, 01 or 11) means the pre-selected chip answers
        resp_now = st_reg.selected;
        stat_now = ST_OK;
      end
    end else if (!st_reg.faulted) begin
      if (st_reg.searching) begin
        resp_now = peer_miss && st_reg.local_hit;
        stat_now = st_reg.local_multi ? ST_MULTI : ST_SINGLE;
      end else begin
        resp_now = st_reg.selected;
        stat_now = ST_OK;
      end
    end
  end

  // ==========================================================
  // Sequencing
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    st_next.is_slave = role_lvl;
    case (st_reg.phase)
      PH_IDLE: begin
        st_next.oe = 1'b0;
        st_next.respond = 1'b0;
        if (i_req_start) begin
          st_next.phase = PH_BUSY;
          st_next.searching = is_search;
          st_next.faulted = i_parity_err || i_cmd_err;
          st_next.local_known = 1'b0;
          st_next.local_hit = 1'b0;
          st_next.local_multi = 1'b0;
          if (i_req_code == REQ_TEST) begin
            st_next.selected = i_test_word[TEST_SEL_BIT] ==
                               role_lvl;
          end else if (is_search) begin
            st_next.selected = 1'b1;
          end else begin
            st_next.selected = id_slave == role_lvl;
          end
          if (i_parity_err || i_cmd_err) begin
            st_next.cs_out = CS_IDLE;
          end else if (is_search) begin
            st_next.cs_out = CS_IDLE;
          end else begin
            st_next.cs_out = CS_DIRECT;
          end
          // Slave data held off until the decision is known
          st_next.permit = 1'b0;
        end
      end
      PH_BUSY: begin
        if (st_reg.searching && !st_reg.faulted && i_local_valid) begin
          st_next.local_known = 1'b1;
          st_next.local_hit = i_local_hit || i_local_multi;
          st_next.local_multi = i_local_multi;
          st_next.cs_out = (i_local_hit || i_local_multi) ?
                           CS_HIT : CS_MISS;
        end
        // Unselected chip still tracks the request to its end
        if (i_req_end) begin
          st_next.phase = PH_DONE;
          st_next.respond = resp_now;
          st_next.status = resp_now ? stat_now : ST_OK;
          // Master allows slave drive only when it stays silent
          st_next.permit = !st_reg.faulted && !resp_now;
          st_next.oe = resp_now && i_read_cycle &&
                       (!st_reg.is_slave || ci_lvl[2]);
          st_next.dout = i_read_data;
        end
      end
      PH_DONE: begin
        st_next.phase = PH_IDLE;
        st_next.oe = 1'b0;
        st_next.respond = 1'b0;
        st_next.cs_out = CS_IDLE;
        st_next.permit = 1'b0;
        st_next.faulted = 1'b0;
      end
      default: begin
        st_next.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign o_cascade_status_out = st_reg.cs_out;
  assign o_slave_output_permit = st_reg.is_slave ? 1'b0 : st_reg.permit;
  assign o_req_ready = (st_reg.phase == PH_IDLE);
  assign o_selected = st_reg.selected;
  assign o_respond = st_reg.respond;
  assign o_overall_status = st_reg.status;
  assign o_data_bus_lines_out = st_reg.dout;
  assign o_data_bus_lines_oe = st_reg.oe;

  // ==========================================================
  // Checks
  // ==========================================================
  reset_outputs_a: assert property (@(posedge i_mclk)
    !i_rstn |-> (o_cascade_status_out == 2'h0 && !o_data_bus_lines_oe))
    else $error("outputs active during reset");
  slave_silent_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) st_reg.is_slave |->
    o_overall_status < ST_CASC_ERR)
    else $error("slave reported an error status");
  hit_code_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (st_reg.phase == PH_BUSY && st_reg.searching
    && !st_reg.faulted && i_local_valid && i_local_hit && !i_req_end)
    |=> o_cascade_status_out == CS_HIT)
    else $error("hit not shown as 01");
  fault_code_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (o_req_ready && i_req_start && i_cmd_err)
    |=> o_cascade_status_out == CS_IDLE)
    else $error("error request not shown as 10");
  busy_wait_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (o_req_ready && i_req_start) |=>
    !o_req_ready until_with i_req_end)
    else $error("new request taken before end");
  no_resp_oe_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) !o_respond |-> !o_data_bus_lines_oe)
    else $error("bus driven by non-responder");
  permit_fault_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) st_reg.faulted |-> !o_slave_output_permit)
    else $error("slave permitted during fault");
  done_release_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) st_reg.phase == PH_DONE |=>
    (!o_data_bus_lines_oe && !o_slave_output_permit))
    else $error("drive held past answer cycle");

  // Answer edge and chip matches, shared by the checks below
  logic at_end;
  logic id_match;
  logic test_match;
  assign at_end = (st_reg.phase == PH_BUSY) && i_req_end;
  assign id_match = (id_slave == role_lvl);
  assign test_match = (i_test_word[TEST_SEL_BIT] == role_lvl);

  master_yield_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && !st_reg.is_slave &&
    st_reg.searching && !st_reg.faulted && !st_reg.local_hit &&
    peer_hit) |=> !o_respond)
    else $error("master answered over a slave hit");
  master_answer_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && !st_reg.is_slave &&
    st_reg.searching && !st_reg.faulted &&
    (st_reg.local_hit || peer_miss)) |=> o_respond)
    else $error("master silent at search end");
  both_hit_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && !st_reg.is_slave &&
    st_reg.searching && !st_reg.faulted && st_reg.local_hit &&
    peer_hit) |=> o_overall_status == ST_MULTI)
    else $error("two hits not reported as multimatch");
  search_casc_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && !st_reg.is_slave &&
    st_reg.searching && !st_reg.faulted && (peer_idle || peer_direct))
    |=> o_overall_status == ST_CASC_ERR)
    else $error("search cascade error missed");
  direct_casc_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && !st_reg.is_slave &&
    !st_reg.searching && !st_reg.faulted && peer_idle)
    |=> o_overall_status == ST_CASC_ERR)
    else $error("idle slave not flagged");
  direct_ok_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && !st_reg.is_slave &&
    !st_reg.searching && !st_reg.faulted && !peer_idle)
    |=> o_overall_status == ST_OK)
    else $error("non-search status not ok");
  slave_answer_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && st_reg.is_slave &&
    st_reg.searching && !st_reg.faulted && peer_miss &&
    st_reg.local_hit) |=> o_respond)
    else $error("slave silent on sole hit");
  slave_hold_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && st_reg.is_slave &&
    st_reg.searching && !(peer_miss && st_reg.local_hit))
    |=> !o_respond)
    else $error("slave answered out of turn");
  id_select_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (o_req_ready && i_req_start &&
    (i_req_code == REQ_WRITE || i_req_code == REQ_READ))
    |=> o_selected == $past(id_match))
    else $error("id range picked wrong chip");
  test_select_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (o_req_ready && i_req_start &&
    i_req_code == REQ_TEST) |=> o_selected == $past(test_match))
    else $error("test bit picked wrong chip");
  fault_answer_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) (at_end && !st_reg.is_slave &&
    st_reg.faulted) |=> (o_respond && o_overall_status >= ST_PAR_ERR))
    else $error("master error not reported");
  answer_pulse_a: assert property (@(posedge i_mclk)
    disable iff (!i_rstn) o_respond |=> !o_respond)
    else $error("answer held past one cycle");
endmodule
`default_nettype wire

// [cascade_pkg.sv]
// Constants and types shared by the cascade arbitration logic
package cascade_pkg;
  localparam int ID_W = 14;
  localparam logic [13:0] SLAVE_ID_BASE = 14'h2000;
  localparam int TEST_SEL_BIT = 9;
  localparam int TEST_WORD_W = 16;
  localparam logic [1:0] CS_MISS = 2'h0;
  localparam logic [1:0] CS_HIT = 2'h1;
  localparam logic [1:0] CS_IDLE = 2'h2;
  localparam logic [1:0] CS_DIRECT = 2'h3;
  localparam logic [2:0] REQ_SEARCH1 = 3'h1;
  localparam logic [2:0] REQ_SEARCH2 = 3'h2;
  localparam logic [2:0] REQ_SEARCH3 = 3'h3;
  localparam logic [2:0] REQ_WRITE = 3'h4;
  localparam logic [2:0] REQ_READ = 3'h5;
  localparam logic [2:0] REQ_TEST = 3'h6;
  // Overall status codes
  localparam logic [2:0] ST_OK = 3'h0;
  localparam logic [2:0] ST_MISS = 3'h1;
  localparam logic [2:0] ST_SINGLE = 3'h2;
  localparam logic [2:0] ST_MULTI = 3'h3;
  localparam logic [2:0] ST_CASC_ERR = 3'h4;
  localparam logic [2:0] ST_PAR_ERR = 3'h5;
  localparam logic [2:0] ST_CMD_ERR = 3'h6;
  // Typical system clock, for reference only
  localparam int SYS_CLK_KHZ = 25920;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_BUSY = 2'b01,
    PH_DONE = 2'b11
  } phase_e;
endpackage

// [pin_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync import cascade_pkg::*; #(
  parameter int W = 3
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_s;
  sync_s st_reg;
  sync_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Change taken once stages two and three agree
    for (int b = 0; b < W; b++) begin
      if (st_reg.s2[b] == st_reg.s3[b]) begin
        st_next.lvl[b] = st_reg.s3[b];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.lvl;
endmodule
`default_nettype wire

// [cascade_peer_model.sv]
// Behavioural model of the paired peer chip acting as slave or, with i_act_master set, as master
`timescale 1ns/1ps
`default_nettype none
module cascade_peer_model import cascade_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [1:0] i_status,
  input wire logic i_act_master,
  input wire logic i_permit,
  output logic [1:0] o_cascade_status_out,
  output logic o_slave_output_permit
);
  // ==========================================================
  // Cascade outputs
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cascade_status_out <= 2'h0;
      o_slave_output_permit <= 1'b0;
    end else begin
      o_cascade_status_out <= i_status;
      // Defined only when acting as master; never steady on a slave
      o_slave_output_permit <= i_act_master ? i_permit :
                               ~o_slave_output_permit;
    end
  end
endmodule
`default_nettype wire

// [cam_cascade_arbiter_bench.sv]
// Bench for the cascade arbiter as master and then as slave beside a peer model
`timescale 1ns/1ps
`default_nettype none
module cam_cascade_arbiter_bench import cascade_pkg::*;;
  logic mclk, rstn, start, lvalid, lhit, lmulti, rend, rdcyc;
  logic par, cerr, permit_in, permit, ready, sel, resp, oe;
  logic role, permit_set;
  logic [1:0] peer_set, csin, cs_out;
  logic [2:0] code, stat;
  logic [ID_W-1:0] id;
  logic [TEST_WORD_W-1:0] tword;
  logic [32:0] rdata, dout;
  int err_total, compares;

  // ==========================================================
  // Instances
  cam_cascade_arbiter cam_cascade_arbiter_inst (
    .i_mclk(mclk), .i_rstn(rstn), .i_cascade_role_select(role),
    .i_cascade_status_in(csin), .i_output_permit_in(permit_in),
    .i_req_start(start), .i_req_code(code),
    .i_local_connection_id(id), .i_test_word(tword),
    .i_parity_err(par), .i_cmd_err(cerr), .i_local_valid(lvalid),
    .i_local_hit(lhit), .i_local_multi(lmulti), .i_req_end(rend),
    .i_read_cycle(rdcyc), .i_read_data(rdata),
    .o_cascade_status_out(cs_out), .o_slave_output_permit(permit),
    .o_req_ready(ready), .o_selected(sel), .o_respond(resp),
    .o_overall_status(stat), .o_data_bus_lines_out(dout),
    .o_data_bus_lines_oe(oe));
  cascade_peer_model cascade_peer_model_inst (
    .i_mclk(mclk), .i_rstn(rstn), .i_status(peer_set),
    .i_act_master(role), .i_permit(permit_set),
    .o_cascade_status_out(csin), .o_slave_output_permit(permit_in));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic tick;
    @(posedge mclk);
    #2;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Expect is {respond, oe, permit, status}; res is {multi, hit}
  task automatic req(input logic [2:0] c, input logic [13:0] cid,
      input logic [15:0] tw, input logic [1:0] peer,
      input logic [1:0] res, input logic [1:0] er, input logic [5:0] ex);
    int n;
    peer_set = peer;
    {cerr, par} = er;
    // Peer status must clear the three-stage synchroniser
    repeat (5) tick();
    start = 1'b1;
    code = c;
    id = cid;
    tword = tw;
    tick();
    start = 1'b0;
    check(ready, 1'b0);
    if (c > REQ_SEARCH3) begin
      check(cs_out, (er != 2'h0) ? CS_IDLE : CS_DIRECT);
    end else begin
      lvalid = 1'b1;
      {lmulti, lhit} = res;
      tick();
      lvalid = 1'b0;
      tick();
      check(cs_out, (er != 2'h0) ? CS_IDLE : {1'b0, res[0]});
    end
    repeat (2) tick();
    rend = 1'b1;
    rdcyc = (c == REQ_READ);
    rdata = {1'b1, 18'h0, cid};
    tick();
    rend = 1'b0;
    rdcyc = 1'b0;
    check({resp, oe, permit, stat}, ex);
    if (c <= REQ_SEARCH3) check(sel, 1'b1);
    else if (er == 2'h0 && peer != CS_IDLE) check(sel, ex[5]);
    if (ex[4]) check(dout, rdata);
    {cerr, par} = 2'h0;
    n = 0;
    while (ready !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    if (ready !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic sc_reset;
    rstn = 1'b0;
    repeat (16) tick();
    check({cs_out, permit, oe, ready}, 5'h01);
    rstn = 1'b1;
    repeat (4) tick();
    check(ready, 1'b1);
  endtask

  task automatic sc_search;
    req(REQ_SEARCH1, 14'h0, 16'h0, CS_MISS, 2'h0, 2'h0, 6'h21);
    req(REQ_SEARCH2, 14'h0, 16'h0, CS_MISS, 2'h1, 2'h0, 6'h22);
    req(REQ_SEARCH3, 14'h0, 16'h0, CS_HIT, 2'h0, 2'h0, 6'h08);
    req(REQ_SEARCH1, 14'h0, 16'h0, CS_HIT, 2'h1, 2'h0, 6'h23);
    req(REQ_SEARCH3, 14'h0, 16'h0, CS_MISS, 2'h3, 2'h0, 6'h23);
  endtask

  task automatic sc_select;
    req(REQ_WRITE, 14'h1fff, 16'h0, CS_DIRECT, 2'h0, 2'h0, 6'h20);
    req(REQ_WRITE, 14'h2000, 16'h0, CS_DIRECT, 2'h0, 2'h0, 6'h08);
    req(REQ_READ, 14'h1fff, 16'h0, CS_DIRECT, 2'h0, 2'h0, 6'h30);
    req(REQ_READ, 14'h3fff, 16'h0, CS_DIRECT, 2'h0, 2'h0, 6'h08);
    req(REQ_TEST, 14'h0, 16'h0200, CS_DIRECT, 2'h0, 2'h0, 6'h08);
    req(REQ_TEST, 14'h0, 16'hfdff, CS_DIRECT, 2'h0, 2'h0, 6'h20);
  endtask

  task automatic sc_errors;
    req(REQ_SEARCH1, 14'h0, 16'h0, CS_IDLE, 2'h1, 2'h0, 6'h24);
    req(REQ_SEARCH2, 14'h0, 16'h0, CS_DIRECT, 2'h1, 2'h0, 6'h24);
    req(REQ_WRITE, 14'h5, 16'h0, CS_IDLE, 2'h0, 2'h0, 6'h24);
    req(REQ_WRITE, 14'h5, 16'h0, CS_MISS, 2'h0, 2'h0, 6'h20);
    req(REQ_WRITE, 14'h5, 16'h0, CS_DIRECT, 2'h0, 2'h0, 6'h20);
    req(REQ_READ, 14'h5, 16'h0, CS_HIT, 2'h0, 2'h1, 6'h35);
    req(REQ_SEARCH1, 14'h0, 16'h0, CS_HIT, 2'h0, 2'h2, 6'h26);
  endtask

  task automatic sc_midreset;
    start = 1'b1;
    code = REQ_READ;
    tick();
    start = 1'b0;
    rstn = 1'b0;
    tick();
    check({cs_out, permit, oe}, 4'h0);
    rstn = 1'b1;
    repeat (4) tick();
    check(ready, 1'b1);
    req(REQ_WRITE, 14'h0, 16'h0, CS_MISS, 2'h0, 2'h0, 6'h20);
  endtask

  // Block as slave; the peer model then acts as master
  task automatic sc_slave;
    role = 1'b1;
    permit_set = 1'b1;
    req(REQ_SEARCH1, 14'h0, 16'h0, CS_MISS, 2'h1, 2'h0, 6'h22);
    req(REQ_SEARCH2, 14'h0, 16'h0, CS_HIT, 2'h3, 2'h0, 6'h00);
    req(REQ_SEARCH3, 14'h0, 16'h0, CS_MISS, 2'h0, 2'h0, 6'h00);
    req(REQ_READ, 14'h2000, 16'h0, CS_DIRECT, 2'h0, 2'h0, 6'h30);
    req(REQ_READ, 14'h1fff, 16'h0, CS_DIRECT, 2'h0, 2'h0, 6'h00);
    req(REQ_TEST, 14'h0, 16'h0200, CS_DIRECT, 2'h0, 2'h0, 6'h20);
    req(REQ_READ, 14'h2000, 16'h0, CS_DIRECT, 2'h0, 2'h1, 6'h00);
    permit_set = 1'b0;
    req(REQ_READ, 14'h2000, 16'h0, CS_DIRECT, 2'h0, 2'h0, 6'h20);
  endtask

  initial begin
    err_total = 0;
    compares = 0;
    {rstn, start, lvalid, lhit, lmulti, rend, rdcyc, par, cerr} = '0;
    peer_set = CS_MISS;
    {role, permit_set} = 2'h0;
    code = 3'h0;
    id = '0;
    tword = '0;
    rdata = '0;
    sc_reset();
    sc_search();
    sc_select();
    sc_errors();
    sc_midreset();
    sc_slave();
    print_verdict();
  end
endmodule
`default_nettype wire
